// ===== hw/adcss_pkg.sv
// Constants, register map and types shared by the summation/shifter block.
// Assumes a 32-bit classic Wishbone bus and a 24-bit converter result path.
package adcss_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_SUM0 = 5'h04;
    localparam logic [4:0] OFF_SUM1 = 5'h08;
    localparam logic [4:0] OFF_SUM2 = 5'h0c;
    localparam logic [4:0] OFF_SUM3 = 5'h10;
    localparam logic [4:0] OFF_STAT = 5'h14;
    localparam logic [4:0] OFF_MASK = 5'h18;
    localparam logic [4:0] OFF_CFG = 5'h1c;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int CNT_MSB = 5;
    localparam int CNT_LSB = 3;
    localparam int SHF_MSB = 2;
    localparam int SHF_LSB = 0;
    localparam int STAT_DONE_BIT = 6;
    localparam int CFG_BIPOLAR_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] STAT_VALID = 8'h40;
    localparam logic [7:0] CFG_VALID = 8'h01;

    // ****************************************************************
    // Widths and timing
    // ****************************************************************
    localparam int CONV_W = 24;
    localparam int CNT_W = 9;
    localparam int SHIFT_CYCLES = 4;
    localparam logic [1:0] SHIFT_STEP = 2'h2;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'h0,
        MODE_AUTO = 2'h1,
        MODE_SHIFT = 2'h2,
        MODE_ACCSHIFT = 2'h3
    } adcss_mode_e;

    typedef enum logic [1:0] {ST_IDLE, ST_ACCUM, ST_SHIFT} adcss_state_e;

endpackage : adcss_pkg

// ===== hw/adcss_shifter.sv
// Multi-cycle logical right shifter for the summation block.
// Assumes start is a one-cycle pulse and value is held for that cycle only.
`timescale 1ns/100ps
`default_nettype none
module adcss_shifter (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [31:0] value,
    input wire logic [2:0] shiftField,
    output logic [31:0] result,
    output logic done
);
    import adcss_pkg::*;

    logic [3:0] remain, next_remain;
    logic [2:0] cycle, next_cycle;
    logic busy, next_busy;
    logic [31:0] next_result;
    logic next_done;
    logic [1:0] step;

    // ****************************************************************
    // Shift sequencer
    // ****************************************************************
    // Two bits per cycle keeps the barrel small while a distance of
    // eight still finishes inside the fixed four-cycle budget.
    always_comb begin
        next_remain = remain;
        next_cycle = cycle;
        next_busy = busy;
        next_result = result;
        next_done = 1'b0;
        step = (remain >= 4'(SHIFT_STEP)) ? SHIFT_STEP : remain[1:0];
        if (start) begin
            next_result = value;
            next_remain = 4'({1'b0, shiftField}) + 4'h1;
            next_cycle = 3'h0;
            next_busy = 1'b1;
        end else if (busy) begin
            next_result = result >> step;
            next_remain = remain - 4'(step);
            if (cycle == 3'(SHIFT_CYCLES - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cycle = cycle + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            remain <= 4'h0;
            cycle <= 3'h0;
            busy <= 1'b0;
            result <= 32'h0;
            done <= 1'b0;
        end else begin
            remain <= next_remain;
            cycle <= next_cycle;
            busy <= next_busy;
            result <= next_result;
            done <= next_done;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_four_cycles;
        // Four shifting edges follow the start edge; the registered done is seen on the fifth.
        @(posedge core_clk) disable iff (!arst_n) start |-> ##5 done;
    endproperty
    a_four_cycles: assert property (p_four_cycles) else $error("shift not done on time");

    property p_shift_value;
        @(posedge core_clk) disable iff (!arst_n)
            done |-> result == ($past(value, 5) >> (4'($past(shiftField, 5)) + 4'h1));
    endproperty
    a_shift_value: assert property (p_shift_value) else $error("shift result wrong");

    property p_shift_distance;
        @(posedge core_clk) disable iff (!arst_n)
            start && shiftField == 3'h7 |=> remain == 4'h8;
    endproperty
    a_shift_distance: assert property (p_shift_distance) else $error("bad distance");

endmodule : adcss_shifter
`default_nettype wire

// ===== hw/adcss_top.sv
// Summation/shifter block: 32-bit accumulator fed by CPU or converter.
// Assumes a classic Wishbone master and converter results on core_clk.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Low sum byte write adds staged word in manual mode when idle
// - Control write of zero clears, selects manual
// - Auto mode sums selected count of results
// - Completion raises enabled summation interrupt
// - Completion sets done flag bit six
// - Control 0x50 sums eight results
// - Shift mode logically shifts accumulator right
// - Control 0x82 shifts right by three
// - Accumulate-and-shift sums then shifts
// - Control 0xdb averages sixteen results
// - Shift completes in four clock cycles
// - Inactive while converter powered down; a result or shift finishing as power drops still lands in the sum
// - Bipolar results sign-extended before adding
// - Shift distance is field plus one
module adcss_top (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [adcss_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic convPowered,
    input wire logic convValid,
    input wire logic [adcss_pkg::CONV_W-1:0] convData,
    output logic irq
);
    import adcss_pkg::*;

    function automatic logic [CNT_W-1:0] sampleTarget(input logic [2:0] field);
        sampleTarget = 9'h002 << field;
    endfunction : sampleTarget

    function automatic logic [31:0] extendSample(input logic [CONV_W-1:0] d,
                                                 input logic bipolar);
        extendSample = {{(32 - CONV_W){bipolar & d[CONV_W-1]}}, d};
    endfunction : extendSample

    logic [7:0] ctrl, next_ctrl;
    logic [7:0] stage1, next_stage1;
    logic [7:0] stage2, next_stage2;
    logic [7:0] stage3, next_stage3;
    logic [7:0] status, next_status;
    logic [7:0] mask, next_mask;
    logic [7:0] cfg, next_cfg;
    logic [31:0] acc, next_acc;
    logic [CNT_W-1:0] sampleCnt, next_sampleCnt;
    adcss_state_e state, next_state;
    logic next_irq;
    logic next_ack;
    logic [31:0] next_datO;
    logic req, wr, setDone, shStart, shDone;
    logic [31:0] shResult;
    logic [7:0] wdat;
    adcss_mode_e mode, newMode;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];
    assign mode = adcss_mode_e'(ctrl[MODE_MSB:MODE_LSB]);
    assign newMode = adcss_mode_e'(wdat[MODE_MSB:MODE_LSB]);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Every access, mapped or not, is answered one cycle after the request.
    always_comb begin
        next_ack = req;
        next_datO = wb_dat_o;
        if (req && !wb_we_i) begin
            if (wb_adr_i == OFF_CTRL) begin
                next_datO = {24'h0, ctrl};
            end else if (wb_adr_i == OFF_SUM0) begin
                next_datO = {24'h0, acc[7:0]};
            end else if (wb_adr_i == OFF_SUM1) begin
                next_datO = {24'h0, acc[15:8]};
            end else if (wb_adr_i == OFF_SUM2) begin
                next_datO = {24'h0, acc[23:16]};
            end else if (wb_adr_i == OFF_SUM3) begin
                next_datO = {24'h0, acc[31:24]};
            end else if (wb_adr_i == OFF_STAT) begin
                next_datO = {24'h0, status};
            end else if (wb_adr_i == OFF_MASK) begin
                next_datO = {24'h0, mask};
            end else if (wb_adr_i == OFF_CFG) begin
                next_datO = {24'h0, cfg};
            end else begin
                next_datO = 32'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_datO;
        end
    end

    // ****************************************************************
    // Accumulator, sequencer and registers
    // ****************************************************************
    always_comb begin
        next_ctrl = ctrl;
        next_stage1 = stage1;
        next_stage2 = stage2;
        next_stage3 = stage3;
        next_mask = mask;
        next_cfg = cfg;
        next_acc = acc;
        next_sampleCnt = sampleCnt;
        next_state = state;
        setDone = 1'b0;
        shStart = 1'b0;
        case (state)
            ST_ACCUM: begin
                if (convValid) begin
                    // Bit 32 of the sum is simply not kept.
                    next_acc = acc + extendSample(convData, cfg[CFG_BIPOLAR_BIT]);
                    next_sampleCnt = sampleCnt + 9'h001;
                    if (next_sampleCnt == sampleTarget(ctrl[CNT_MSB:CNT_LSB])) begin
                        if (mode == MODE_ACCSHIFT) begin
                            shStart = 1'b1;
                            next_state = ST_SHIFT;
                        end else begin
                            setDone = 1'b1;
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            ST_SHIFT: begin
                if (shDone) begin
                    next_acc = shResult;
                    setDone = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (wr) begin
            if (wb_adr_i == OFF_CTRL) begin
                // A control write aborts whatever was running.
                next_ctrl = wdat;
                next_sampleCnt = '0;
                next_state = ST_IDLE;
                shStart = 1'b0;
                setDone = 1'b0;
                if (wdat == 8'h00) begin
                    next_acc = 32'h0;
                end else if (convPowered) begin
                    case (newMode)
                        MODE_AUTO, MODE_ACCSHIFT: begin
                            next_state = ST_ACCUM;
                        end
                        MODE_SHIFT: begin
                            shStart = 1'b1;
                            next_state = ST_SHIFT;
                        end
                        default: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end
            end else if (wb_adr_i == OFF_SUM0) begin
                if (convPowered && mode == MODE_MANUAL && state == ST_IDLE) begin
                    next_acc = acc + {stage3, stage2, stage1, wdat};
                end
            end else if (wb_adr_i == OFF_SUM1) begin
                next_stage1 = wdat;
            end else if (wb_adr_i == OFF_SUM2) begin
                next_stage2 = wdat;
            end else if (wb_adr_i == OFF_SUM3) begin
                next_stage3 = wdat;
            end else if (wb_adr_i == OFF_MASK) begin
                next_mask = wdat & STAT_VALID;
            end else if (wb_adr_i == OFF_CFG) begin
                next_cfg = wdat & CFG_VALID;
            end
        end
        // Dropping converter power abandons any run; a result or shift finishing in this same cycle still lands in the sum.
        if (!convPowered) begin
            next_state = ST_IDLE;
            next_sampleCnt = '0;
            shStart = 1'b0;
            setDone = 1'b0;
        end
        // Clearing takes effect first so a completion in the same cycle stays set.
        next_status = status;
        if (wr && wb_adr_i == OFF_STAT) begin
            next_status = status & ~wdat;
        end
        if (setDone) begin
            next_status[STAT_DONE_BIT] = 1'b1;
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= CTRL_RST;
            stage1 <= 8'h00;
            stage2 <= 8'h00;
            stage3 <= 8'h00;
            status <= STAT_RST;
            mask <= MASK_RST;
            cfg <= CFG_RST;
            acc <= 32'h0;
            sampleCnt <= '0;
            state <= ST_IDLE;
            irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
            status <= next_status;
            mask <= next_mask;
            cfg <= next_cfg;
            acc <= next_acc;
            sampleCnt <= next_sampleCnt;
            state <= next_state;
            irq <= next_irq;
        end
    end

    adcss_shifter u_shifter (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(shStart),
        .value(next_acc),
        .shiftField(next_ctrl[SHF_MSB:SHF_LSB]),
        .result(shResult),
        .done(shDone)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_manual_add;
        wr && wb_adr_i == OFF_SUM0 && convPowered && mode == MODE_MANUAL && state == ST_IDLE
            |=> acc == $past(acc) + {$past(stage3), $past(stage2), $past(stage1), $past(wdat)};
    endproperty
    a_manual_add: assert property (p_manual_add) else $error("manual add wrong");

    property p_clear;
        wr && wb_adr_i == OFF_CTRL && wdat == 8'h00
            |=> acc == 32'h0 && mode == MODE_MANUAL && state == ST_IDLE;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_count_bound;
        state == ST_ACCUM |-> sampleCnt < sampleTarget(ctrl[CNT_MSB:CNT_LSB]);
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("count overrun");

    property p_irq;
        status[STAT_DONE_BIT] && mask[STAT_DONE_BIT] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_done_flag;
        setDone |=> status[STAT_DONE_BIT];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag lost");

    property p_auto8;
        wr && wb_adr_i == OFF_CTRL && wdat == 8'h50 && convPowered
            |=> state == ST_ACCUM && sampleTarget(ctrl[CNT_MSB:CNT_LSB]) == 9'h008;
    endproperty
    a_auto8: assert property (p_auto8) else $error("0x50 not auto x8");

    property p_shift82;
        wr && wb_adr_i == OFF_CTRL && wdat == 8'h82 && convPowered
            |-> shStart ##1 state == ST_SHIFT && ctrl[SHF_MSB:SHF_LSB] == 3'h2;
    endproperty
    a_shift82: assert property (p_shift82) else $error("0x82 not shift 3");

    property p_then_shift;
        state == ST_ACCUM && convValid && convPowered && !wr && mode == MODE_ACCSHIFT
            && sampleCnt + 9'h001 == sampleTarget(ctrl[CNT_MSB:CNT_LSB]) |=> state == ST_SHIFT;
    endproperty
    a_then_shift: assert property (p_then_shift) else $error("no shift after sum");

    property p_avg16;
        wr && wb_adr_i == OFF_CTRL && wdat == 8'hdb && convPowered
            |=> state == ST_ACCUM && sampleTarget(ctrl[CNT_MSB:CNT_LSB]) == 9'h010
            && ctrl[SHF_MSB:SHF_LSB] == 3'h3;
    endproperty
    a_avg16: assert property (p_avg16) else $error("0xdb not avg 16");

    property p_power;
        !convPowered |=> state == ST_IDLE && $stable(acc);
    endproperty
    a_power: assert property (p_power) else $error("active while unpowered");

    property p_sign_ext;
        state == ST_ACCUM && convValid && convPowered && !wr && cfg[CFG_BIPOLAR_BIT]
            |=> acc == $past(acc) + {{8{$past(convData[CONV_W-1])}}, $past(convData)};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extend wrong");

    c_auto_done: cover property (state == ST_ACCUM && setDone);
    c_shift_done: cover property (state == ST_SHIFT && shDone);
    c_manual_add: cover property (wr && wb_adr_i == OFF_SUM0 && mode == MODE_MANUAL);
    c_irq: cover property (irq);

endmodule : adcss_top
`default_nettype wire

// ===== dv/adcss_conv_model.sv
// Behavioural model of the converter result path feeding the summation block.
// Assumes one clock domain shared with the block; results are one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module adcss_conv_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [8:0] count,
    input wire logic [3:0] gap,
    input wire logic [23:0] first,
    input wire logic [23:0] step,
    output logic convValid,
    output logic [23:0] convData,
    output logic busy
);
    logic [8:0] left;
    logic [3:0] idle;
    logic [23:0] nextVal;

    // ****************************************************************
    // Result sequencer
    // ****************************************************************
    // Between strobes the data bus toggles every cycle, so a block that
    // samples it without the strobe sees garbage rather than a stale result.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            convValid <= 1'b0;
            convData <= 24'h000000;
            left <= 9'h000;
            idle <= 4'h0;
            nextVal <= 24'h000000;
        end else begin
            convValid <= 1'b0;
            convData <= ~convData;
            if (start) begin
                left <= count;
                idle <= 4'h0;
                nextVal <= first;
            end else if (left != 9'h000) begin
                if (idle != 4'h0) begin
                    idle <= idle - 4'h1;
                end else begin
                    convValid <= 1'b1;
                    convData <= nextVal;
                    nextVal <= nextVal + step;
                    left <= left - 9'h001;
                    idle <= gap;
                end
            end
        end
    end

    assign busy = (left != 9'h000);
endmodule : adcss_conv_model
`default_nettype wire

// ===== dv/tb_adcss_top.sv
// Self-checking bench for the summation/shifter block.
// Assumes the block answers classic Wishbone cycles and takes converter strobes.
`timescale 1ns/100ps
`default_nettype none
module tb_adcss_top;
    import adcss_pkg::*;
    logic core_clk;
    logic arst_n;
    logic wbCyc, wbStb, wbWe;
    logic [ADDR_W-1:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDat;
    logic [31:0] wbDatOut;
    logic wbAck, irq, convPowered, convValid, cnvStart, cnvBusy;
    logic [23:0] convData, cnvFirst, cnvStep;
    logic [8:0] cnvCount;
    logic [3:0] cnvGap;
    logic [31:0] s, expv;
    logic [23:0] d;
    int errTotal = 0;
    int checkCount = 0;

    adcss_top u_adcss_top (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .convPowered(convPowered),
        .convValid(convValid), .convData(convData), .irq(irq));
    adcss_conv_model u_adcss_conv_model (.core_clk(core_clk), .arst_n(arst_n),
        .start(cnvStart), .count(cnvCount), .gap(cnvGap), .first(cnvFirst),
        .step(cnvStep), .convValid(convValid), .convData(convData), .busy(cnvBusy));

    always #50 core_clk = ~core_clk;

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checkCount++;
        if (got !== e) begin
            errTotal++;
            $display("unexpected %s: expected %h seen %h", what, e, got);
        end
    endtask : chk

    // Entered just after a rising edge; ack is read before that edge's updates land.
    task automatic wbXfer(input logic we, input logic [4:0] adr, input logic [7:0] wd,
                          output logic [7:0] rd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'h1;
        wbDat <= {24'h000000, wd};
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            errTotal++;
            results();
        end
        rd = wbDatOut[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge core_clk);
    endtask : wbXfer

    task automatic wbWr(input logic [4:0] adr, input logic [7:0] wd);
        logic [7:0] unused;
        wbXfer(1'b1, adr, wd, unused);
    endtask : wbWr

    task automatic rdChk(input string what, input logic [4:0] adr, input logic [7:0] e);
        logic [7:0] rd;
        wbXfer(1'b0, adr, 8'h00, rd);
        chk(what, {24'h000000, e}, {24'h000000, rd});
        chk({what, " upper"}, 32'h0, {8'h00, wbDatOut[31:8]});
    endtask : rdChk

    task automatic addWord(input logic [31:0] v);
        wbWr(OFF_SUM3, v[31:24]);
        wbWr(OFF_SUM2, v[23:16]);
        wbWr(OFF_SUM1, v[15:8]);
        wbWr(OFF_SUM0, v[7:0]);
    endtask : addWord

    task automatic readSum(output logic [31:0] v);
        logic [7:0] b0, b1, b2, b3;
        wbXfer(1'b0, OFF_SUM0, 8'h00, b0);
        wbXfer(1'b0, OFF_SUM1, 8'h00, b1);
        wbXfer(1'b0, OFF_SUM2, 8'h00, b2);
        wbXfer(1'b0, OFF_SUM3, 8'h00, b3);
        v = {b3, b2, b1, b0};
    endtask : readSum

    task automatic waitDone();
        logic [7:0] st;
        int n;
        n = 0;
        st = 8'h00;
        while (st[STAT_DONE_BIT] !== 1'b1) begin
            if (n == 200) begin
                errTotal++;
                results();
            end
            wbXfer(1'b0, OFF_STAT, 8'h00, st);
            n++;
        end
    endtask : waitDone

    task automatic runConv(input logic [8:0] c, input logic [3:0] g,
                           input logic [23:0] f, input logic [23:0] st);
        int n;
        n = 0;
        cnvCount <= c;
        cnvGap <= g;
        cnvFirst <= f;
        cnvStep <= st;
        cnvStart <= 1'b1;
        @(posedge core_clk);
        cnvStart <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (cnvBusy !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            errTotal++;
            results();
        end
        @(posedge core_clk);
    endtask : runConv

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        {wbCyc, wbStb, wbWe, cnvStart} = 4'h0;
        wbAdr = '0;
        wbSel = 4'h0;
        wbDat = 32'h00000000;
        convPowered = 1'b1;
        {cnvCount, cnvGap, cnvFirst, cnvStep} = '0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk("irq after reset", 32'h0, {31'h0, irq});
        rdChk("control reset", OFF_CTRL, CTRL_RST);
        rdChk("status reset", OFF_STAT, STAT_RST);
        rdChk("mask reset", OFF_MASK, MASK_RST);
        rdChk("config reset", OFF_CFG, CFG_RST);
        rdChk("unmapped read", 5'h02, 8'h00);
        // Two staged words summed by low-byte writes.
        wbWr(OFF_CTRL, 8'h00);
        addWord(32'h00123456);
        wbWr(OFF_SUM1, 8'h77);
        addWord(32'h0051ab04);
        readSum(s);
        chk("manual sum", 32'h0063df5a, s);
        wbWr(OFF_CTRL, 8'h00);
        readSum(s);
        chk("cleared sum", 32'h00000000, s);
        addWord(32'hffffffff);
        addWord(32'h00000003);
        readSum(s);
        chk("wrapped sum", 32'h00000002, s);
        // Divide by eight with the interrupt enabled.
        wbWr(OFF_MASK, 8'h40);
        rdChk("mask readback", OFF_MASK, 8'h40);
        wbWr(OFF_CTRL, 8'h00);
        addWord(32'h01516612);
        wbWr(OFF_CTRL, 8'h82);
        rdChk("status early", OFF_STAT, 8'h00);
        rdChk("status at four", OFF_STAT, 8'h40);
        chk("irq on shift", 32'h1, {31'h0, irq});
        readSum(s);
        chk("divide by 8", 32'h002a2cc2, s);
        wbWr(OFF_STAT, 8'h40);
        rdChk("status cleared", OFF_STAT, 8'h00);
        chk("irq cleared", 32'h0, {31'h0, irq});
        for (int f = 0; f < 8; f++) begin
            wbWr(OFF_CTRL, 8'h00);
            addWord(32'hf000000f);
            wbWr(OFF_CTRL, {5'h10, 3'(f)});
            waitDone();
            readSum(s);
            chk("shift distance", 32'hf000000f >> (f + 1), s);
            wbWr(OFF_STAT, 8'h40);
        end
        // Eight unipolar results summed from ten offered back to back.
        wbWr(OFF_CTRL, 8'h00);
        wbWr(OFF_CTRL, 8'h50);
        runConv(9'd10, 4'h0, 24'h800000, 24'h000001);
        expv = 32'h0;
        for (int i = 0; i < 8; i++) begin
            expv = expv + {8'h00, 24'h800000 + 24'(i)};
        end
        rdChk("auto done", OFF_STAT, 8'h40);
        chk("irq auto", 32'h1, {31'h0, irq});
        readSum(s);
        chk("auto sum", expv, s);
        wbWr(OFF_STAT, 8'h40);
        // Sixteen bipolar results averaged, slow source, interrupt masked.
        wbWr(OFF_MASK, 8'h00);
        wbWr(OFF_CFG, 8'h01);
        rdChk("config readback", OFF_CFG, 8'h01);
        wbWr(OFF_CTRL, 8'h00);
        wbWr(OFF_CTRL, 8'hdb);
        runConv(9'd16, 4'h2, 24'hffff00, 24'h000003);
        expv = 32'h0;
        for (int i = 0; i < 16; i++) begin
            d = 24'hffff00 + 24'(3 * i);
            expv = expv + {{8{d[23]}}, d};
        end
        waitDone();
        chk("irq masked", 32'h0, {31'h0, irq});
        readSum(s);
        chk("average", expv >> 4, s);
        wbWr(OFF_STAT, 8'h40);
        wbWr(OFF_CFG, 8'h00);
        // Converter unpowered: results must not reach the sum.
        wbWr(OFF_CTRL, 8'h00);
        addWord(32'h00000005);
        convPowered <= 1'b0;
        wbWr(OFF_CTRL, 8'h50);
        runConv(9'd8, 4'h0, 24'h000100, 24'h000001);
        rdChk("no done unpowered", OFF_STAT, 8'h00);
        readSum(s);
        chk("sum held unpowered", 32'h00000005, s);
        convPowered <= 1'b1;
        results();
    end
endmodule : tb_adcss_top
`default_nettype wire
